// ---- hdl/pscc_top.sv ----
`timescale 1ns/1ns

// Operation
// RQ1 - LEDs are grouped in segments of eight, addressed by segment number.
// RQ2 - Each setpoint is one 32-bit word, red low byte, white high byte.
// RQ3 - First pixel of a segment sits at segment number times eight.
// RQ4 - Write request on trigger stores all eight elements into the pixel buffer.
// RQ5 - Commit request on trigger copies the pixel buffer into the frame buffer.
// RQ6 - Auto output enable sends the frame buffer without any send request.
// RQ7 - Send request on trigger starts one frame transmission.
// RQ8 - One trigger performs write, then commit, then send.
// RQ9 - Busy rises on a trigger and no command is accepted until it clears.
// RQ10 - Master waits for busy low before toggling the trigger again.
// RQ11 - Frame output active is high for the whole frame transmission.
// RQ12 - Commit and send are refused while a frame is being sent.
// RQ13 - Master waits for frame output inactive before new frame writes.
// RQ14 - Send done toggle inverts on each successful send.
// RQ15 - Commit done toggle inverts on successful commit, not when refused.
// RQ16 - Command done toggle inverts on each successful command.
// RQ17 - Refused is set when busy, length zero, or pixels beyond count; the code refuses on length zero or pixels beyond count for write commands only.
// RQ18 - Commit and send together with one trigger update and transmit.
// RQ19 - A trigger is any change of the trigger bit versus the last value.
module pscc_top (
    // Clock and reset.
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Strip side.
    output logic      [31:0] PIXEL_DATA,
    output logic             PIXEL_VALID,
    output logic             FRAME_ACTIVE,
    // Interrupt.
    output logic             IRQ
);

    logic [31:0]                   pix_mem [pscc_pkg::PIX_DEPTH];
    logic [31:0]                   frm_mem [pscc_pkg::PIX_DEPTH];
    logic [31:0]                   elem_q  [pscc_pkg::SEG_LEDS];
    logic [3:0]                    ctrl_q;
    logic                          trig_seen_q;
    logic [pscc_pkg::SEG_AW-1:0]   seg_q;
    logic                          auto_q;
    logic [pscc_pkg::PIX_AW:0]     count_q;
    logic [pscc_pkg::PIX_AW-1:0]   rd_addr_q;
    pscc_pkg::pscc_state_t         state_q;
    logic                          busy_q;
    logic                          do_commit_q;
    logic                          do_send_q;
    logic [pscc_pkg::PIX_AW:0]     idx_q;
    logic                          active_q;
    logic [pscc_pkg::PIX_AW:0]     tx_idx_q;
    logic [15:0]                   tx_tick_q;
    logic                          send_ack_q;
    logic                          commit_ack_q;
    logic                          cmd_ack_q;
    logic                          refused_q;
    logic [pscc_pkg::IRQ_WIDTH-1:0] irq_stat_q;
    logic [pscc_pkg::IRQ_WIDTH-1:0] irq_mask_q;
    logic [pscc_pkg::IRQ_WIDTH-1:0] irq_ev;
    logic                          wr_en;
    logic                          rd_en;
    logic                          trigger;
    logic                          seg_bad;
    logic                          accept;
    logic                          start_tx;
    logic                          tx_done;
    logic                          manual_tx_q;
    logic [pscc_pkg::PIX_AW:0]     seg_base;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;

    // Segment base pixel is the segment number times eight.
    assign seg_base = {seg_q, 3'h0 , 1'h0} >> 1;  // [RQ1] [RQ3]

    // Any edge of the trigger bit against the last sampled value is a trigger.
    assign trigger = ctrl_q[pscc_pkg::CTRL_TRIG_BIT] != trigger_prev();  // [RQ19]

    function automatic logic trigger_prev();
        return trig_seen_q;
    endfunction : trigger_prev

    // Segment must lie wholly inside the configured pixel count.
    assign seg_bad = (count_q == '0) || ((seg_base + 9'h008) > count_q);  // [RQ17]
    assign accept  = trigger && !busy_q && !(ctrl_q[pscc_pkg::CTRL_WRITE_BIT] && seg_bad);

    // APB register writes.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            ctrl_q     <= 4'h0;
            seg_q      <= '0;
            auto_q     <= 1'b0;
            count_q    <= pscc_pkg::PIX_COUNT_RST;
            rd_addr_q  <= '0;
            irq_mask_q <= '0;
        end else if (wr_en) begin
            unique case (PADDR)
                pscc_pkg::ADDR_CTRL:     ctrl_q <= PWDATA[3:0];
                pscc_pkg::ADDR_SEGMENT:  seg_q  <= PWDATA[pscc_pkg::SEG_AW-1:0];
                pscc_pkg::ADDR_CONFIG: begin
                    auto_q  <= PWDATA[pscc_pkg::CFG_AUTO_BIT];
                    count_q <= PWDATA[pscc_pkg::CFG_COUNT_LSB +: 9];
                end
                pscc_pkg::ADDR_RD_ADDR:  rd_addr_q  <= PWDATA[pscc_pkg::PIX_AW-1:0];
                pscc_pkg::ADDR_IRQ_MASK: irq_mask_q <= PWDATA[pscc_pkg::IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // Element setpoints, one word each, red in the low byte.
    generate
        for (genvar e = 0; e < pscc_pkg::SEG_LEDS; e++) begin : g_elem
            always_ff @(posedge CORE_CLK) begin
                if (!RESETN) begin
                    elem_q[e] <= pscc_pkg::ZERO_WORD;
                end else if (wr_en && PADDR == pscc_pkg::ADDR_ELEM0 + 8'(4 * e)) begin
                    elem_q[e] <= PWDATA;  // [RQ2]
                end
            end
        end
    endgenerate

    // Trigger sample tracks the trigger bit every cycle.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            trig_seen_q <= 1'b0;
        end else begin
            trig_seen_q <= ctrl_q[pscc_pkg::CTRL_TRIG_BIT];
        end
    end

    // Command sequencer: write, then commit, then send.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            state_q     <= pscc_pkg::PSCC_IDLE;
            busy_q      <= 1'b0;
            do_commit_q <= 1'b0;
            do_send_q   <= 1'b0;
            idx_q       <= '0;
        end else begin
            unique case (state_q)
                pscc_pkg::PSCC_IDLE: begin
                    if (accept) begin
                        busy_q      <= 1'b1;  // [RQ9]
                        do_commit_q <= ctrl_q[pscc_pkg::CTRL_COMMIT_BIT] && !active_q;  // [RQ12]
                        do_send_q   <= ctrl_q[pscc_pkg::CTRL_SEND_BIT] && !active_q;  // [RQ12]
                        idx_q       <= '0;
                        state_q     <= ctrl_q[pscc_pkg::CTRL_WRITE_BIT] ?
                                       pscc_pkg::PSCC_WRITE : pscc_pkg::PSCC_COMMIT;  // [RQ8]
                    end
                end
                pscc_pkg::PSCC_WRITE: begin
                    idx_q <= idx_q + 9'h001;
                    if (idx_q == 9'(pscc_pkg::SEG_LEDS - 1)) begin
                        idx_q   <= '0;
                        state_q <= pscc_pkg::PSCC_COMMIT;  // [RQ8]
                    end
                end
                pscc_pkg::PSCC_COMMIT: begin
                    if (!do_commit_q || idx_q == 9'(pscc_pkg::PIX_DEPTH - 1)) begin
                        state_q <= pscc_pkg::PSCC_FINISH;  // [RQ8]
                    end else begin
                        idx_q <= idx_q + 9'h001;
                    end
                end
                pscc_pkg::PSCC_FINISH: begin
                    busy_q  <= 1'b0;  // [RQ9]
                    state_q <= pscc_pkg::PSCC_IDLE;
                end
            endcase
        end
    end

    // Pixel buffer written at segment base plus element.
    always_ff @(posedge CORE_CLK) begin
        if (state_q == pscc_pkg::PSCC_WRITE) begin
            pix_mem[8'(seg_base + idx_q)] <= elem_q[idx_q[2:0]];  // [RQ4] [RQ3]
        end
    end

    // Frame buffer copied word by word from the pixel buffer.
    always_ff @(posedge CORE_CLK) begin
        if (state_q == pscc_pkg::PSCC_COMMIT && do_commit_q) begin
            frm_mem[idx_q[7:0]] <= pix_mem[idx_q[7:0]];  // [RQ5] [RQ18]
        end
    end

    // Transmission starts on a send request or automatically when idle.
    assign start_tx = !active_q && ((state_q == pscc_pkg::PSCC_FINISH && do_send_q)  // [RQ7]
                      || (auto_q && !busy_q && !accept));  // [RQ6]
    assign tx_done  = active_q && tx_tick_q == 16'(pscc_pkg::PIXEL_CYCLES - 1)
                      && tx_idx_q == count_q - 9'h001;

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            active_q     <= 1'b0;
            FRAME_ACTIVE <= 1'b0;
            manual_tx_q  <= 1'b0;
            tx_idx_q    <= '0;
            tx_tick_q   <= '0;
            PIXEL_DATA  <= pscc_pkg::ZERO_WORD;
            PIXEL_VALID <= 1'b0;
        end else begin
            PIXEL_VALID <= 1'b0;
            if (start_tx && count_q != '0) begin
                active_q     <= 1'b1;  // [RQ11]
                FRAME_ACTIVE <= 1'b1;  // [RQ11]
                manual_tx_q  <= state_q == pscc_pkg::PSCC_FINISH && do_send_q;  // [RQ14]
                tx_idx_q    <= '0;
                tx_tick_q   <= '0;
            end else if (active_q) begin
                if (tx_tick_q == 16'h0000) begin
                    PIXEL_DATA  <= frm_mem[tx_idx_q[7:0]];
                    PIXEL_VALID <= 1'b1;
                end
                if (tx_done) begin
                    active_q     <= 1'b0;  // [RQ11]
                    FRAME_ACTIVE <= 1'b0;  // [RQ11]
                end else if (tx_tick_q == 16'(pscc_pkg::PIXEL_CYCLES - 1)) begin
                    tx_tick_q <= '0;
                    tx_idx_q  <= tx_idx_q + 9'h001;
                end else begin
                    tx_tick_q <= tx_tick_q + 16'h0001;
                end
            end
        end
    end

    // Acknowledge toggles and refused flag.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            send_ack_q   <= 1'b0;
            commit_ack_q <= 1'b0;
            cmd_ack_q    <= 1'b0;
            refused_q    <= 1'b0;
        end else begin
            if (tx_done && manual_tx_q) begin
                send_ack_q <= !send_ack_q;  // [RQ14]
            end
            if (state_q == pscc_pkg::PSCC_FINISH) begin
                cmd_ack_q <= !cmd_ack_q;  // [RQ16]
                if (do_commit_q) begin
                    commit_ack_q <= !commit_ack_q;  // [RQ15]
                end
            end
            if (trigger) begin
                refused_q <= !accept;  // [RQ17] [RQ10]
            end
        end
    end

    // Interrupt status: set wins over write-one-to-clear.
    assign irq_ev[pscc_pkg::IRQ_DONE_BIT]    = state_q == pscc_pkg::PSCC_FINISH;
    assign irq_ev[pscc_pkg::IRQ_REFUSED_BIT] = trigger && !accept;
    assign irq_ev[pscc_pkg::IRQ_SENT_BIT]    = tx_done;

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            irq_stat_q <= '0;
            IRQ        <= 1'b0;
        end else begin
            if (wr_en && PADDR == pscc_pkg::ADDR_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~PWDATA[pscc_pkg::IRQ_WIDTH-1:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // APB read data, registered in the setup phase, no wait states.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            PRDATA  <= pscc_pkg::ZERO_WORD;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA  <= pscc_pkg::ZERO_WORD;
            if (PSEL && !PENABLE && !PWRITE) begin
                unique case (PADDR)
                    pscc_pkg::ADDR_CTRL:     PRDATA <= {28'h0, ctrl_q};
                    pscc_pkg::ADDR_SEGMENT:  PRDATA <= {27'h0, seg_q};
                    pscc_pkg::ADDR_CONFIG:   PRDATA <= {15'h0, count_q, 7'h0, auto_q};
                    pscc_pkg::ADDR_STATUS:   PRDATA <= {26'h0, refused_q, cmd_ack_q,
                                                        commit_ack_q, send_ack_q,
                                                        active_q, busy_q};
                    pscc_pkg::ADDR_IRQ_STAT: PRDATA <= {29'h0, irq_stat_q};
                    pscc_pkg::ADDR_IRQ_MASK: PRDATA <= {29'h0, irq_mask_q};
                    pscc_pkg::ADDR_RD_ADDR:  PRDATA <= {24'h0, rd_addr_q};
                    pscc_pkg::ADDR_RD_PIX:   PRDATA <= pix_mem[rd_addr_q];
                    pscc_pkg::ADDR_RD_FRM:   PRDATA <= frm_mem[rd_addr_q];
                    default: begin
                        if (PADDR >= pscc_pkg::ADDR_ELEM0 && PADDR < 8'h40) begin
                            PRDATA <= elem_q[PADDR[4:2]];
                        end else begin
                            PSLVERR <= 1'b1;
                        end
                    end
                endcase
            end else if (PSEL && !PENABLE) begin
                PSLVERR <= !(PADDR inside {pscc_pkg::ADDR_CTRL, pscc_pkg::ADDR_SEGMENT,
                             pscc_pkg::ADDR_CONFIG, pscc_pkg::ADDR_IRQ_STAT,
                             pscc_pkg::ADDR_IRQ_MASK, pscc_pkg::ADDR_RD_ADDR})
                           && !(PADDR >= pscc_pkg::ADDR_ELEM0 && PADDR < 8'h40);
            end
        end
    end

    // Checks.
    sequence s_cmd_start;
        state_q == pscc_pkg::PSCC_IDLE && accept;
    endsequence

    property p_busy_rise;
        @(posedge CORE_CLK) disable iff (!RESETN)
        s_cmd_start |=> busy_q;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("Busy did not rise."); // [RQ9]

    property p_busy_ends;
        @(posedge CORE_CLK) disable iff (!RESETN)
        s_cmd_start |-> ##[1:300] !busy_q;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("Busy stuck."); // [RQ8]

    property p_no_start_busy;
        @(posedge CORE_CLK) disable iff (!RESETN)
        busy_q == (state_q != pscc_pkg::PSCC_IDLE);
    endproperty
    a_no_start_busy: assert property (p_no_start_busy) else $error("Start while busy."); // [RQ9]

    property p_refuse_busy;
        @(posedge CORE_CLK) disable iff (!RESETN)
        trigger && busy_q |=> refused_q;
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("Refusal missing."); // [RQ17]

    property p_commit_ack;
        @(posedge CORE_CLK) disable iff (!RESETN)
        state_q == pscc_pkg::PSCC_FINISH && !do_commit_q |=> $stable(commit_ack_q);
    endproperty
    a_commit_ack: assert property (p_commit_ack) else $error("Commit ack toggled."); // [RQ15]

    property p_cmd_ack;
        @(posedge CORE_CLK) disable iff (!RESETN)
        state_q == pscc_pkg::PSCC_FINISH |=> cmd_ack_q != $past(cmd_ack_q);
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("Command ack missing."); // [RQ16]

    property p_send_ack;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !active_q && $past(active_q) && $past(manual_tx_q) |-> $changed(send_ack_q);
    endproperty
    a_send_ack: assert property (p_send_ack) else $error("Send ack missing."); // [RQ14]

    property p_no_commit_active;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (s_cmd_start and active_q) |=> !do_commit_q && !do_send_q;
    endproperty
    a_no_commit_active: assert property (p_no_commit_active) else $error("Frame op in tx."); // [RQ12]

    property p_write_len;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (s_cmd_start and ctrl_q[pscc_pkg::CTRL_WRITE_BIT])
            |=> (state_q == pscc_pkg::PSCC_WRITE) [*8] ##1 state_q == pscc_pkg::PSCC_COMMIT;
    endproperty
    a_write_len: assert property (p_write_len) else $error("Write length wrong."); // [RQ4]

endmodule : pscc_top

// ---- hdl/pscc_pkg.sv ----
package pscc_pkg;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_SEGMENT  = 8'h04;
    localparam logic [7:0] ADDR_CONFIG   = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_ELEM0    = 8'h20;
    localparam logic [7:0] ADDR_RD_ADDR  = 8'h40;
    localparam logic [7:0] ADDR_RD_PIX   = 8'h44;
    localparam logic [7:0] ADDR_RD_FRM   = 8'h48;

    // Control register fields.
    localparam int CTRL_WRITE_BIT  = 0;
    localparam int CTRL_COMMIT_BIT = 1;
    localparam int CTRL_SEND_BIT   = 2;
    localparam int CTRL_TRIG_BIT   = 3;

    // Configuration register fields.
    localparam int CFG_AUTO_BIT  = 0;
    localparam int CFG_COUNT_LSB = 8;

    // Status register fields.
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_ACTIVE_BIT  = 1;
    localparam int ST_SEND_ACK    = 2;
    localparam int ST_COMMIT_ACK  = 3;
    localparam int ST_CMD_ACK     = 4;
    localparam int ST_REFUSED_BIT = 5;

    // Interrupt event bits.
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_REFUSED_BIT = 1;
    localparam int IRQ_SENT_BIT    = 2;
    localparam int IRQ_WIDTH       = 3;

    // Geometry.
    localparam int SEG_LEDS   = 8;
    localparam int SEG_SHIFT  = 3;
    localparam int PIX_DEPTH  = 256;
    localparam int PIX_AW     = 8;
    localparam int SEG_AW     = 5;

    // Reset values.
    localparam logic [PIX_AW:0] PIX_COUNT_RST = 9'h100;
    localparam logic [31:0]     ZERO_WORD     = 32'h0000_0000;

    // Time of one pixel on the strip, in ns, and derived cycle count.
    localparam int PIXEL_TIME_NS  = 30000;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int PIXEL_CYCLES   = (PIXEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PSCC_IDLE,
        PSCC_WRITE,
        PSCC_COMMIT,
        PSCC_FINISH
    } pscc_state_t;

endpackage : pscc_pkg

// ---- bench/pscc_strip_model.sv ----
`timescale 1ns/1ns

// Strip receiver that records the word presented at the start of each pixel slot.
module pscc_strip_model (
    // Strip side.
    input  wire logic        clk,
    input  wire logic        valid,
    input  wire logic [31:0] data
);
    int          n = 0;
    logic [31:0] pix [0:255];

    always @(posedge clk) begin
        if (valid === 1'b1) begin
            pix[n % 256] <= data;
            n <= n + 1;
        end
    end
endmodule : pscc_strip_model

// ---- bench/tb.sv ----
`timescale 1ns/1ns

module tb;
    logic        CORE_CLK = 1'b0;
    logic        RESETN   = 1'b0;
    logic        PSEL     = 1'b0;
    logic        PENABLE  = 1'b0;
    logic        PWRITE   = 1'b0;
    logic [7:0]  PADDR    = 8'h00;
    logic [31:0] PWDATA   = 32'h0000_0000;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [31:0] PIXEL_DATA;
    logic        PIXEL_VALID;
    logic        FRAME_ACTIVE;
    logic        IRQ;
    logic [31:0] rd;
    logic        er;
    logic        trg      = 1'b0;
    logic        sa       = 1'b0;
    logic        ca       = 1'b0;
    logic        da       = 1'b0;
    logic        rf       = 1'b0;
    int          errors   = 0;
    int          checked  = 0;

    always #10 CORE_CLK = ~CORE_CLK;

    pscc_top i_pscc_top (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PIXEL_DATA(PIXEL_DATA),
        .PIXEL_VALID(PIXEL_VALID), .FRAME_ACTIVE(FRAME_ACTIVE), .IRQ(IRQ)
    );

    pscc_strip_model i_pscc_strip_model (
        .clk(CORE_CLK), .valid(PIXEL_VALID), .data(PIXEL_DATA)
    );

    task end_of_test;
        $display("Checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 64);
        if (n >= 64) begin
            errors++;
            end_of_test();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // Polls the status word until the chosen bit reads low.
    task wait_low(input int b, input int lim);
        int n;
        n = 0;
        do begin
            apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
            n++;
        end while (rd[b] !== 1'b0 && n < lim);
        if (n >= lim) begin
            errors++;
            end_of_test();
        end
    endtask : wait_low

    function logic [31:0] pv(input int i);
        return 32'h4030_2010 + 32'(i);
    endfunction : pv

    function logic [31:0] stx(input logic act);
        return {26'h0, rf, da, ca, sa, act, 1'b0};
    endfunction : stx

    // Loads a segment, then toggles the trigger with the given requests.
    task cmd(input int seg, input logic [2:0] req);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, pscc_pkg::ADDR_ELEM0 + 8'(4 * k), pv(seg * 8 + k));
        end
        apb(1'b1, pscc_pkg::ADDR_SEGMENT, 32'(seg));
        trg = ~trg;
        apb(1'b1, pscc_pkg::ADDR_CTRL, {28'h0, trg, req});
    endtask : cmd

    task t_reset;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_rst", rd, 32'h0000_0000);
        apb(1'b0, pscc_pkg::ADDR_CONFIG, 32'h0000_0000);
        chk("config_rst", rd, 32'h0001_0000);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk("unmapped", {31'h0, er}, 32'h0000_0001);
        apb(1'b1, pscc_pkg::ADDR_CONFIG, 32'h0000_1000);
        apb(1'b1, pscc_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        $display("Test reset done");
    endtask : t_reset

    task t_combined;
        cmd(0, 3'b001);
        wait_low(pscc_pkg::ST_BUSY_BIT, 50);
        da = ~da;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_write", rd, stx(1'b0));
        cmd(1, 3'b111);
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("busy", {31'h0, rd[0]}, 32'h0000_0001);
        wait_low(pscc_pkg::ST_BUSY_BIT, 300);
        da = ~da;
        ca = ~ca;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_all", rd, stx(1'b1));
        chk("frame_active", {31'h0, FRAME_ACTIVE}, 32'h0000_0001);
        $display("Test combined done");
    endtask : t_combined

    task t_active;
        cmd(0, 3'b110);
        wait_low(pscc_pkg::ST_BUSY_BIT, 300);
        da = ~da;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_blocked", rd, stx(1'b1));
        cmd(0, 3'b001);
        trg = ~trg;
        apb(1'b1, pscc_pkg::ADDR_CTRL, {28'h0, trg, 3'b001});
        wait_low(pscc_pkg::ST_BUSY_BIT, 50);
        da = ~da;
        rf = 1'b1;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_busy_ref", rd, stx(1'b1));
        cmd(0, 3'b001);
        wait_low(pscc_pkg::ST_BUSY_BIT, 50);
        da = ~da;
        rf = 1'b0;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_ok", rd, stx(1'b1));
        cmd(2, 3'b001);
        wait_low(pscc_pkg::ST_BUSY_BIT, 50);
        rf = 1'b1;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_range", rd, stx(1'b1));
        apb(1'b1, pscc_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
        apb(1'b1, pscc_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge CORE_CLK);
        chk("irq_set", {31'h0, IRQ}, 32'h0000_0001);
        apb(1'b1, pscc_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge CORE_CLK);
        chk("irq_clear", {31'h0, IRQ}, 32'h0000_0000);
        $display("Test active done");
    endtask : t_active

    task t_frame;
        wait_low(pscc_pkg::ST_ACTIVE_BIT, 12000);
        sa = ~sa;
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_sent", rd, stx(1'b0));
        chk("frame_idle", {31'h0, FRAME_ACTIVE}, 32'h0000_0000);
        apb(1'b0, pscc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        chk("irq_sent", rd, 32'h0000_0004);
        chk("pixel_count", 32'(i_pscc_strip_model.n), 32'd16);
        for (int i = 0; i < 16; i++) begin
            chk("pixel", i_pscc_strip_model.pix[i], pv(i));
        end
        $display("Test frame done");
    endtask : t_frame

    task t_auto;
        int n;
        n = 0;
        apb(1'b1, pscc_pkg::ADDR_CONFIG, 32'h0000_1001);
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (i_pscc_strip_model.n < 17 && n < 3000);
        chk("auto_pixel", 32'(i_pscc_strip_model.n), 32'd17);
        apb(1'b0, pscc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("auto_status", rd, stx(1'b1));
        chk("auto_active", {31'h0, FRAME_ACTIVE}, 32'h0000_0001);
        $display("Test auto done");
    endtask : t_auto

    initial begin
        repeat (8) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        t_reset();
        t_combined();
        t_active();
        t_frame();
        t_auto();
        end_of_test();
    end
endmodule : tb
